/* File: rtl/qadc_core.sv */
module qadc_core #(
   parameter int POR_CYCLES = qadc_pkg::POR_CYCLES,
   parameter int SPI_TIMEOUT = qadc_pkg::SPI_TIMEOUT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sync_reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic [qadc_pkg::CH_NUM-1:0] mod_bits,
   input wire logic [2:0] osr_sel,
   input wire logic [qadc_pkg::CH_NUM-1:0][qadc_pkg::SAMPLE_W-1:0] cal_offset,
   input wire logic [qadc_pkg::CH_NUM-1:0][qadc_pkg::SAMPLE_W-1:0] cal_gain,
   output logic sample_ready_strobe,
   output logic modulator_clock,
   output logic dout,
   output logic dout_oe_n,
   output logic [23:0] host_word,
   output logic host_word_valid
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [3:0] pin_meta;
   logic [3:0] pin_s;
   wire [3:0] pin_raw = {sync_reset_n, sclk, cs_n, din};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= qadc_pkg::PIN_IDLE;
         pin_s <= qadc_pkg::PIN_IDLE;
      end else begin
         pin_meta <= pin_raw;
         pin_s <= pin_meta;
      end
   end

   // ------------------------------------------------------------
   // sync and reset pin
   // ------------------------------------------------------------
   logic sync_prev;
   logic [11:0] low_cnt;
   wire sync_low = !pin_s[qadc_pkg::PIN_SYNC];
   // a short pulse is judged at release; a long low resets the device while still low
   wire sync_req = !sync_low && !sync_prev && low_cnt != 12'h0
      && low_cnt <= 12'(qadc_pkg::SYNC_MAX);
   wire dev_reset = sync_low && low_cnt >= 12'(qadc_pkg::RESET_LOW - 1);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_prev <= 1'b1;
         low_cnt <= 12'h0;
      end else begin
         sync_prev <= pin_s[qadc_pkg::PIN_SYNC];
         if (!sync_low) low_cnt <= 12'h0;
         else if (low_cnt != 12'(qadc_pkg::RESET_LOW)) low_cnt <= low_cnt + 12'h1;
      end
   end

   // ------------------------------------------------------------
   // start-up sequence
   // ------------------------------------------------------------
   qadc_pkg::qadc_start_type st;
   qadc_pkg::qadc_start_type next_st;
   logic [31:0] start_cnt;
   logic [3:0] osr_log2;
   wire acq_end = st == qadc_pkg::ST_ACQ
      && start_cnt == 32'(qadc_pkg::ACQ_CYCLES - 1);
   wire por_hit = st == qadc_pkg::ST_WAIT
      && start_cnt == 32'(POR_CYCLES - 1);
   wire [3:0] next_osr_log2 = qadc_pkg::OSR_LOG2_MIN + {1'b0, osr_sel};

   always_comb begin
      unique case (st)
         qadc_pkg::ST_ACQ: next_st = acq_end ? qadc_pkg::ST_WAIT : qadc_pkg::ST_ACQ;
         qadc_pkg::ST_WAIT: next_st = por_hit ? qadc_pkg::ST_RUN : qadc_pkg::ST_WAIT;
         qadc_pkg::ST_RUN: next_st = qadc_pkg::ST_RUN;
         default: next_st = qadc_pkg::ST_ACQ;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= qadc_pkg::ST_ACQ;
         start_cnt <= 32'h0;
      end else if (dev_reset) begin
         st <= qadc_pkg::ST_ACQ;
         start_cnt <= 32'h0;
      end else begin
         st <= next_st;
         if (st != qadc_pkg::ST_RUN) start_cnt <= start_cnt + 32'h1;
      end
   end

   // ratio is taken only at a boundary so no conversion mixes two rates
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         osr_log2 <= qadc_pkg::OSR_LOG2_DEF;
      end else if (dev_reset) begin
         osr_log2 <= qadc_pkg::OSR_LOG2_DEF;
      end else if (acq_end || sync_req) begin
         osr_log2 <= next_osr_log2;
      end
   end

   // ------------------------------------------------------------
   // modulator clock and conversion timing
   // ------------------------------------------------------------
   logic [15:0] conv_cnt;
   wire mod_tick = !modulator_clock;
   wire running = st != qadc_pkg::ST_ACQ;
   wire [15:0] conv_len = 16'(qadc_pkg::MOD_DIV) << osr_log2;
   wire conv_end = running && conv_cnt == conv_len - 16'h1;
   wire dump = conv_end || por_hit;
   wire dec_clear = sync_req || !running;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         modulator_clock <= 1'b0;
      end else begin
         modulator_clock <= !modulator_clock;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_cnt <= 16'h0;
      end else if (!running || sync_req || dump) begin
         conv_cnt <= 16'h0;
      end else begin
         conv_cnt <= conv_cnt + 16'h1;
      end
   end

   // ------------------------------------------------------------
   // per-channel filters
   // ------------------------------------------------------------
   logic [qadc_pkg::CH_NUM-1:0][qadc_pkg::SAMPLE_W-1:0] res;
   logic [qadc_pkg::CH_NUM-1:0] res_valid;

   for (genvar ch = 0; ch < qadc_pkg::CH_NUM; ch++) begin : g_ch
      qadc_decim u_decim (
         .clk(ref_clk),
         .rst_n(rst_n),
         .tick(mod_tick),
         .clear(dec_clear),
         .dump(dump),
         .bit_in(mod_bits[ch]),
         .osr_log2(osr_log2),
         .offset(cal_offset[ch]),
         .gain(cal_gain[ch]),
         .result(res[ch]),
         .result_valid(res_valid[ch])
      );
   end

   // ------------------------------------------------------------
   // result frame and data ready
   // ------------------------------------------------------------
   logic [qadc_pkg::FRAME_W-1:0] frame;
   logic [3:0] sample_ready_strobe_cnt;
   wire [qadc_pkg::FRAME_W-1:0] next_frame = {res[0], res[1], res[2], res[3]};
   // a result landing inside a running pulse is stored but not flagged
   wire sample_ready_strobe_fire = res_valid[0] && st == qadc_pkg::ST_RUN && sample_ready_strobe_cnt == 4'h0;
   wire [3:0] next_sample_ready_strobe_cnt = sample_ready_strobe_fire ? qadc_pkg::SAMPLE_READY_STROBE_HIGH + qadc_pkg::SAMPLE_READY_STROBE_LOW
      : (sample_ready_strobe_cnt != 4'h0 ? sample_ready_strobe_cnt - 4'h1 : 4'h0);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame <= '0;
      end else if (res_valid[0]) begin
         frame <= next_frame;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_ready_strobe_cnt <= 4'h0;
         sample_ready_strobe <= 1'b0;
      end else if (dev_reset) begin
         // a device reset cuts a running pulse, no strobe outside run
         sample_ready_strobe_cnt <= 4'h0;
         sample_ready_strobe <= 1'b0;
      end else begin
         sample_ready_strobe_cnt <= next_sample_ready_strobe_cnt;
         sample_ready_strobe <= next_sample_ready_strobe_cnt > qadc_pkg::SAMPLE_READY_STROBE_LOW;
      end
   end

   // ------------------------------------------------------------
   // serial port
   // ------------------------------------------------------------
   logic sclk_d;
   wire cs_low = !pin_s[qadc_pkg::PIN_CS];
   // clock edges compare the synchronised pin with its level one clock earlier
   wire sclk_rise = pin_s[qadc_pkg::PIN_SCLK] && !sclk_d;
   wire sclk_fall = !pin_s[qadc_pkg::PIN_SCLK] && sclk_d;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= pin_s[qadc_pkg::PIN_SCLK];
      end
   end

   qadc_spi #(
      .TIMEOUT(SPI_TIMEOUT)
   ) u_spi (
      .clk(ref_clk),
      .rst_n(rst_n),
      .cs_low(cs_low),
      .sclk_rise(sclk_rise),
      .sclk_fall(sclk_fall),
      .din_s(pin_s[qadc_pkg::PIN_DIN]),
      .frame(frame),
      .dout(dout),
      .dout_oe_n(dout_oe_n),
      .host_word(host_word),
      .host_word_valid(host_word_valid)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [15:0] gap_cnt;
   logic gap_ok;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_cnt <= 16'h0;
         gap_ok <= 1'b0;
      end else begin
         gap_cnt <= dump ? 16'h0 : gap_cnt + 16'h1;
         if (sync_req || !running) gap_ok <= 1'b0;
         else if (dump) gap_ok <= 1'b1;
      end
   end

   sample_ready_strobe_shape_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n || dev_reset)
      $rose(sample_ready_strobe)
      |-> sample_ready_strobe [*4] ##1 !sample_ready_strobe [*4])
      else $error("data ready pulse has wrong shape");

   mod_half_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      modulator_clock |=> !modulator_clock ##1 modulator_clock)
      else $error("modulator clock is not half the main clock");

   conv_period_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      conv_end && gap_ok && !por_hit |-> gap_cnt == conv_len - 16'h1)
      else $error("conversion period is not twice the ratio");

   por_first_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      por_hit |-> ##3 $rose(sample_ready_strobe))
      else $error("first data ready missed its start-up time");

   no_early_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      sample_ready_strobe |-> st == qadc_pkg::ST_RUN)
      else $error("data ready before start-up finished");

   acq_load_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      acq_end |=> st == qadc_pkg::ST_WAIT
      && start_cnt == 32'(qadc_pkg::ACQ_CYCLES) && osr_log2 == $past(next_osr_log2))
      else $error("defaults not loaded at the end of acquisition");

   sync_align_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      sync_req && st == qadc_pkg::ST_RUN && !dev_reset
      |=> st == qadc_pkg::ST_RUN && conv_cnt == 16'h0)
      else $error("short sync pulse did not realign conversions");

   long_reset_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      sync_low && low_cnt == 12'(qadc_pkg::RESET_LOW - 1)
      |=> st == qadc_pkg::ST_ACQ && start_cnt == 32'h0)
      else $error("long sync low did not reset the device");

   joint_sample_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      res_valid[0] |-> &res_valid ##1 frame == $past(next_frame))
      else $error("channels did not deliver together");
endmodule

/* File: rtl/qadc_decim.sv */
module qadc_decim (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic clear,
   input wire logic dump,
   input wire logic bit_in,
   input wire logic [3:0] osr_log2,
   input wire logic [23:0] offset,
   input wire logic [23:0] gain,
   output logic [23:0] result,
   output logic result_valid
);
   // ------------------------------------------------------------
   // integrate and dump of the modulator stream
   // ------------------------------------------------------------
   logic [15:0] ones;
   logic signed [31:0] raw;
   logic v1;
   wire [15:0] ones_now = ones + {15'h0, tick & bit_in};
   wire [15:0] oversampling_ratio = 16'h1 << osr_log2;
   wire signed [17:0] diff = $signed({1'b0, ones_now, 1'b0}) - $signed({2'b00, oversampling_ratio});
   wire [4:0] up = 5'(qadc_pkg::GAIN_FRAC) - {1'b0, osr_log2};
   wire signed [31:0] scaled = 32'(diff) <<< up;
   // ------------------------------------------------------------
   // offset and gain correction, saturated to full scale
   // ------------------------------------------------------------
   wire signed [32:0] corr = 33'(raw) - 33'($signed(offset));
   wire signed [57:0] prod = corr * $signed({1'b0, gain});
   wire signed [34:0] scl = 35'(prod >>> qadc_pkg::GAIN_FRAC);
   wire ovp = !scl[34] && (|scl[33:23]);
   wire ovn = scl[34] && !(&scl[33:23]);
   wire [23:0] next_result = ovp ? 24'h7FFFFF : (ovn ? 24'h800000 : scl[23:0]);
   wire raw_fits = raw == 32'(signed'(raw[23:0]));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ones <= 16'h0;
      end else if (clear || dump) begin
         ones <= 16'h0;
      end else begin
         ones <= ones_now;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         raw <= 32'sh0;
         v1 <= 1'b0;
         result <= 24'h0;
         result_valid <= 1'b0;
      end else begin
         if (dump) raw <= scaled;
         v1 <= dump && !clear;
         if (v1) result <= next_result;
         result_valid <= v1;
      end
   end

   dump_to_valid_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      dump && !clear |-> ##2 result_valid)
      else $error("filter result did not follow its dump");

   unity_cal_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      v1 && raw_fits && gain == qadc_pkg::GAIN_ONE && offset == 24'h0
      |=> result == $past(raw[23:0]))
      else $error("unity calibration altered the sample");
endmodule

/* File: rtl/qadc_pkg.sv */
package qadc_pkg;
   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int MCLK_HZ = 25_000_000;
   localparam int HZ_PER_MHZ = 1_000_000;
   localparam int POR_US = 250;
   localparam int POR_CYCLES = POR_US * (MCLK_HZ / HZ_PER_MHZ);
   localparam int ACQ_US = 5;
   localparam int ACQ_CYCLES = ACQ_US * (MCLK_HZ / HZ_PER_MHZ);
   localparam int SPI_TIMEOUT_CYCLES = 32768;
   localparam int SYNC_MAX = 2047;
   localparam int RESET_LOW = 2048;
   localparam int MOD_DIV = 2;
   localparam logic [3:0] SAMPLE_READY_STROBE_HIGH = 4'h4;
   localparam logic [3:0] SAMPLE_READY_STROBE_LOW = 4'h4;
   // ------------------------------------------------------------
   // data path
   // ------------------------------------------------------------
   localparam int CH_NUM = 4;
   localparam int SAMPLE_W = 24;
   localparam int FRAME_W = CH_NUM * SAMPLE_W;
   localparam int GAIN_FRAC = 23;
   localparam logic [23:0] GAIN_ONE = 24'h800000;
   localparam logic [3:0] OSR_LOG2_MIN = 4'h7;
   localparam logic [3:0] OSR_LOG2_DEF = 4'hA;
   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   localparam int PIN_SYNC = 3;
   localparam int PIN_SCLK = 2;
   localparam int PIN_CS = 1;
   localparam int PIN_DIN = 0;
   localparam logic [3:0] PIN_IDLE = 4'hA;
   typedef enum logic [1:0] {
      ST_ACQ = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b11
   } qadc_start_type;
endpackage

/* File: rtl/qadc_spi.sv */
module qadc_spi #(
   parameter int TIMEOUT = qadc_pkg::SPI_TIMEOUT_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_low,
   input wire logic sclk_rise,
   input wire logic sclk_fall,
   input wire logic din_s,
   input wire logic [qadc_pkg::FRAME_W-1:0] frame,
   output logic dout,
   output logic dout_oe_n,
   output logic [23:0] host_word,
   output logic host_word_valid
);
   logic cs_prev;
   logic [31:0] idle_cnt;
   logic [qadc_pkg::FRAME_W-1:0] tx;
   logic [23:0] rx;
   logic [4:0] rx_cnt;
   // frame is copied at select so a new sample cannot tear a read
   wire cs_start = cs_low && !cs_prev;
   wire timeout = cs_low && idle_cnt == 32'(TIMEOUT - 1);
   wire rx_last = rx_cnt == 5'h17;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev <= 1'b0;
         dout_oe_n <= 1'b1;
         idle_cnt <= 32'h0;
      end else begin
         cs_prev <= cs_low;
         dout_oe_n <= !cs_low;
         if (!cs_low || timeout || sclk_rise || sclk_fall) idle_cnt <= 32'h0;
         else idle_cnt <= idle_cnt + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx <= '0;
         dout <= 1'b0;
      end else if (!cs_low) begin
         dout <= 1'b0;
      end else if (cs_start || timeout) begin
         tx <= frame;
      end else if (sclk_rise) begin
         dout <= tx[qadc_pkg::FRAME_W-1];
         tx <= {tx[qadc_pkg::FRAME_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx <= 24'h0;
         rx_cnt <= 5'h0;
         host_word <= 24'h0;
         host_word_valid <= 1'b0;
      end else begin
         host_word_valid <= 1'b0;
         if (!cs_low || timeout) begin
            rx_cnt <= 5'h0;
         end else if (sclk_fall) begin
            rx <= {rx[22:0], din_s};
            rx_cnt <= rx_last ? 5'h0 : rx_cnt + 5'h1;
            if (rx_last) begin
               host_word <= {rx[22:0], din_s};
               host_word_valid <= 1'b1;
            end
         end
      end
   end

   dout_release_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !cs_low |=> dout_oe_n)
      else $error("output driven while deselected");

   dout_launch_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !dout_oe_n && $changed(dout) |-> $past(sclk_rise))
      else $error("output bit changed without a rising clock");

   din_capture_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      host_word_valid |-> $past(sclk_fall) && host_word[0] == $past(din_s))
      else $error("input word not taken on a falling clock");

   idle_abort_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      timeout |=> rx_cnt == 5'h0 && idle_cnt == 32'h0 && tx == $past(frame))
      else $error("stalled frame not abandoned");
endmodule

/* File: tb/qadc_core_tb.sv */
module qadc_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // setup
   // ------------------------------------------------------------
   localparam int POR_C = 600;
   localparam int TMO = 64;
   logic ref_clk = 1'b0;
   logic rst_n, sync_reset_n, sclk, cs_n, din;
   logic [3:0] mod_bits;
   logic [2:0] osr_sel;
   logic [qadc_pkg::CH_NUM-1:0][qadc_pkg::SAMPLE_W-1:0] cal_offset, cal_gain;
   logic sample_ready_strobe, modulator_clock, dout, dout_oe_n, host_word_valid;
   logic [23:0] host_word, last_word;
   int n_errors = 0;
   int compares = 0;
   int n_words = 0;
   always #20 ref_clk = ~ref_clk;
   qadc_core #(.POR_CYCLES(POR_C), .SPI_TIMEOUT(TMO)) uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .sync_reset_n(sync_reset_n), .sclk(sclk),
      .cs_n(cs_n), .din(din), .mod_bits(mod_bits), .osr_sel(osr_sel),
      .cal_offset(cal_offset), .cal_gain(cal_gain),
      .sample_ready_strobe(sample_ready_strobe), .modulator_clock(modulator_clock),
      .dout(dout), .dout_oe_n(dout_oe_n), .host_word(host_word),
      .host_word_valid(host_word_valid));
   qadc_host host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   always @(posedge ref_clk) begin
      if (host_word_valid === 1'b1) begin
         n_words <= n_words + 1;
         last_word <= host_word;
      end
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      compares++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // counts main clocks to the next strobe rise, bounded
   task automatic wait_rise(output int n);
      n = 0;
      while (sample_ready_strobe === 1'b1 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      while (sample_ready_strobe !== 1'b1 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 3000) begin
         chk_rng("ready wait", 0, 2999, n);
         complete_run();
      end
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_power_up();
      int n, k;
      logic m, nm;
      wait_rise(n);
      chk_rng("first ready", POR_C + 1, POR_C + 8, n);
      k = 1;
      @(negedge ref_clk);
      while (sample_ready_strobe === 1'b1 && k < 20) begin
         k++;
         @(negedge ref_clk);
      end
      chk_rng("ready high", 4, 4, k);
      repeat (4) begin
         m = modulator_clock;
         nm = ~m;
         @(negedge ref_clk);
         chk("modulator toggle", {95'h0, nm}, {95'h0, modulator_clock});
      end
   endtask
   task automatic t_rate();
      int n;
      wait_rise(n);
      wait_rise(n);
      chk_rng("ready period", 256, 256, n);
   endtask
   task automatic t_frame(input int h);
      int n, w0;
      logic [95:0] rx;
      host.half = h;
      wait_rise(n);
      w0 = n_words;
      chk("idle enable", 96'h1, {95'h0, dout_oe_n});
      host.open_frame();
      chk("frame enable", 96'h0, {95'h0, dout_oe_n});
      host.shift(96, {4{24'hA5C31E}}, rx);
      host.close_frame();
      host.wait_clk(4);
      chk("released enable", 96'h1, {95'h0, dout_oe_n});
      chk("frame data", {24'h7FFFFF, 24'h800000, 24'h6DCBAA, 24'h000000}, rx);
      chk_rng("host words", 4, 4, n_words - w0);
      chk("host word", 96'hA5C31E, {72'h0, last_word});
   endtask
   task automatic t_timeout();
      int w0;
      logic [95:0] rx;
      w0 = n_words;
      host.open_frame();
      host.shift(10, 96'h2AA, rx);
      // stall well past the idle limit with select still low
      host.wait_clk(TMO + 40);
      host.shift(24, 96'h3C5A96, rx);
      host.close_frame();
      chk_rng("words after stall", 1, 1, n_words - w0);
      chk("word after stall", 96'h3C5A96, {72'h0, last_word});
   endtask
   task automatic t_sync();
      int n;
      wait_rise(n);
      repeat (100) @(negedge ref_clk);
      // new ratio must only take effect at the sync request
      osr_sel = 3'h1;
      sync_reset_n = 1'b0;
      repeat (10) @(negedge ref_clk);
      sync_reset_n = 1'b1;
      wait_rise(n);
      chk_rng("ready after sync", 510, 530, n);
      wait_rise(n);
      chk_rng("period after sync", 512, 512, n);
   endtask
   task automatic t_reset_pin();
      int n;
      sync_reset_n = 1'b0;
      repeat (2100) @(negedge ref_clk);
      chk("ready in reset", 96'h0, {95'h0, sample_ready_strobe});
      sync_reset_n = 1'b1;
      wait_rise(n);
      chk_rng("ready after reset", POR_C, POR_C + 12, n);
      wait_rise(n);
      chk_rng("period after reset", 512, 512, n);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      sync_reset_n = 1'b1;
      osr_sel = 3'h0;
      mod_bits = 4'h5;
      cal_offset = {24'h000000, 24'h123456, 24'h000000, 24'h000000};
      cal_gain = {24'h000000, qadc_pkg::GAIN_ONE, qadc_pkg::GAIN_ONE, qadc_pkg::GAIN_ONE};
      repeat (4) @(negedge ref_clk);
      chk("reset outputs", 96'h1, {93'h0, sample_ready_strobe, modulator_clock, dout_oe_n});
      rst_n = 1'b1;
      t_power_up();
      t_rate();
      t_frame(5);
      t_frame(8);
      t_timeout();
      t_sync();
      t_reset_pin();
      complete_run();
   end
endmodule

/* File: tb/qadc_host.sv */
// ------------------------------------------------------------
// host side serial controller
// ------------------------------------------------------------
module qadc_host (
   input wire logic ref_clk,
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   timeunit 1ns;
   timeprecision 1ps;
   // half period in main clocks; at least 3 since pins are oversampled
   int half = 5;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic open_frame();
      wait_clk(1);
      cs_n = 1'b0;
      wait_clk(half);
   endtask
   // launch on rise, sample device data just before the fall
   task automatic shift(input int n, input logic [95:0] tx, output logic [95:0] rx);
      rx = 96'h0;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         din = tx[n-1-i];
         wait_clk(half);
         rx = {rx[94:0], dout};
         sclk = 1'b0;
         wait_clk(half);
      end
   endtask
   task automatic close_frame();
      cs_n = 1'b1;
      // released line: never leave the last value standing
      din = ~din;
      wait_clk(4);
   endtask
endmodule
